// ---- shared/bsp_pkg.sv ----
/*
 * Shared constants and carrier types for the buffered synchronous serial port.
 * Assumes a single system clock domain; pin levels arrive raw from the pads.
 */
package bsp_pkg;

   localparam int BSP_CHAR_W = 8;
   localparam int BSP_CNT_W = 4;
   localparam int BSP_BAUD_W = 16;
   localparam int BSP_PIN_W = 4;

   // Shift value presented by a port that has no transmit data.
   localparam logic [7:0] BSP_FILL = 8'hFF;
   // A bits-per-character code of zero selects a full character.
   localparam logic [2:0] BSP_BPC_FULL = 3'h0;
   localparam logic [3:0] BSP_FULL_CHAR = 4'h8;
   // Divisor giving the fastest serial clock, half the system clock.
   localparam logic [15:0] BSP_BAUD_FASTEST = 16'h0001;
   // Half periods of the select lead-in before the first data bit.
   localparam logic [1:0] BSP_PRE_HALVES = 2'h2;

   localparam logic [1:0] BSP_DIR_OFF = 2'h0;
   localparam logic [1:0] BSP_DIR_RX_ONLY = 2'h1;
   localparam logic [1:0] BSP_DIR_TX_ONLY = 2'h2;
   localparam logic [1:0] BSP_DIR_BOTH = 2'h3;

   localparam logic [1:0] BSP_FRAME_SW = 2'h0;
   localparam logic [1:0] BSP_FRAME_PULSE = 2'h2;
   localparam logic [1:0] BSP_FRAME_ALT = 2'h3;

   // Pin order {sck, mosi, miso, ss_n}; only the select idles high.
   localparam logic [3:0] BSP_PIN_IDLE = 4'h1;

   typedef enum logic [1:0] {
      BSP_IDLE,
      BSP_PRE,
      BSP_SHIFT,
      BSP_WAIT
   } bsp_state_t;

   typedef struct packed {
      logic master_mode_enable;
      logic [1:0] direction_enable_pair;
      logic sck_phase;
      logic sck_idle_level;
      logic [1:0] select_framing_mode;
      logic select_pin_direction;
      logic [2:0] bits_per_character;
      logic [15:0] baud_divisor;
   } bsp_cfg_t;

   typedef struct packed {
      logic data_wr;
      logic data_rd;
      logic [7:0] wdata;
      logic select_value;
   } bsp_sw_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } bsp_pins_t;

   typedef struct packed {
      logic tx_buffer_empty;
      logic rx_buffer_full;
      logic irq_tx;
      logic irq_rx;
      logic busy;
   } bsp_status_t;

endpackage

// ---- logic/bsp_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to clk_sys; only the second stage is read outside.
 */
`timescale 1ns/1ps
module bsp_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input logic clk_sys,
   input logic rst_n,
   input logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } bsp_sync_state_t;

   bsp_sync_state_t q;
   bsp_sync_state_t d;

   always_comb begin
      d = q;
      d.meta = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= {RESET_VAL, RESET_VAL};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule

// ---- logic/bsp_baud.sv ----
/*
 * Baud tick generator: one-cycle tick every divisor cycles while running.
 * Assumes the divisor is held steady during a transaction.
 */
`timescale 1ns/1ps
module bsp_baud #(
   parameter int W = bsp_pkg::BSP_BAUD_W
) (
   input logic clk_sys,
   input logic rst_n,
   input logic run,
   input logic [W-1:0] divisor,
   output logic tick
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } bsp_baud_state_t;

   bsp_baud_state_t q;
   bsp_baud_state_t d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (!run) begin
         d.cnt = '0;
      end else if (q.cnt == W'(divisor - W'(1))) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = W'(q.cnt + W'(1));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule

// ---- logic/bsp_top.sv ----
/*
 * Buffered synchronous serial port: one shift register, one data buffer,
 * master or slave over four pins with tri-state controls.
 * Assumes cfg and sw come from logic on clk_sys; pins_in are raw pad levels.
 */
`timescale 1ns/1ps
module bsp_top (
   input logic clk_sys,
   input logic rst_n,
   input bsp_pkg::bsp_cfg_t cfg,
   input bsp_pkg::bsp_sw_t sw,
   input bsp_pkg::bsp_pins_t pins_in,
   output bsp_pkg::bsp_pins_t pins_out,
   output bsp_pkg::bsp_pins_t pins_oe,
   output logic [7:0] data_rdata,
   output bsp_pkg::bsp_status_t status
);

   typedef struct packed {
      bsp_pkg::bsp_state_t st;
      logic [7:0] shift;
      logic [7:0] dbuf;
      logic sck_lvl;
      logic inbit;
      logic first;
      logic ssv_lat;
      logic sck_prev;
      logic [1:0] pre_cnt;
      logic [3:0] bit_cnt;
      bsp_pkg::bsp_pins_t pin_out;
      bsp_pkg::bsp_pins_t pin_oe;
      logic [7:0] rdata;
      bsp_pkg::bsp_status_t stat;
   } bsp_top_state_t;

   bsp_top_state_t q;
   bsp_top_state_t d;
   bsp_pkg::bsp_pins_t pins_s;

   logic enabled;
   logic tx_en;
   logic rx_en;
   logic master;
   logic selected;
   logic slave_lvl;
   logic baud_run;
   logic baud_tick;
   logic lead;
   logic trail;
   logic sample_ev;
   logic shift_ev;
   logic rx_bit;
   logic tx_ok;
   logic rx_ok;
   logic framed;
   logic [3:0] nbits;
   logic char_done;
   logic xfer;
   logic [7:0] done_shift;

   bsp_sync #(
      .WIDTH(bsp_pkg::BSP_PIN_W),
      .RESET_VAL(bsp_pkg::BSP_PIN_IDLE)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(pins_in),
      .sync_out(pins_s)
   );

   bsp_baud #(
      .W(bsp_pkg::BSP_BAUD_W)
   ) u_baud (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(baud_run),
      .divisor(cfg.baud_divisor),
      .tick(baud_tick)
   );

   assign enabled = cfg.direction_enable_pair != bsp_pkg::BSP_DIR_OFF;
   assign tx_en = cfg.direction_enable_pair[1];
   assign rx_en = cfg.direction_enable_pair[0];
   assign master = cfg.master_mode_enable;
   assign selected = !pins_s.ss_n;
   assign slave_lvl = pins_s.sck ^ cfg.sck_idle_level;
   assign baud_run = enabled && master && (q.st == bsp_pkg::BSP_PRE || q.st == bsp_pkg::BSP_SHIFT);
   assign framed = cfg.select_framing_mode == bsp_pkg::BSP_FRAME_PULSE ||
                   cfg.select_framing_mode == bsp_pkg::BSP_FRAME_ALT;

   assign nbits = (cfg.bits_per_character == bsp_pkg::BSP_BPC_FULL) ?
                  bsp_pkg::BSP_FULL_CHAR : {1'b0, cfg.bits_per_character};

   assign lead = master ? (baud_tick && !q.sck_lvl) : (selected && slave_lvl && !q.sck_prev);
   assign trail = master ? (baud_tick && q.sck_lvl) : (selected && !slave_lvl && q.sck_prev);

   assign sample_ev = cfg.sck_phase ? trail : lead;
   assign shift_ev = cfg.sck_phase ? lead : trail;
   assign rx_bit = master ? pins_s.miso : pins_s.mosi;

   // A direction that is switched off never holds the exchange back.
   assign tx_ok = !tx_en || !q.stat.tx_buffer_empty;
   assign rx_ok = !rx_en || !q.stat.rx_buffer_full;

   always_comb begin
      d = q;
      char_done = 1'b0;
      xfer = 1'b0;
      done_shift = q.shift;
      d.sck_prev = slave_lvl;

      if (sw.data_rd && q.stat.rx_buffer_full) begin
         d.stat.rx_buffer_full = 1'b0;
         if (tx_en && rx_en) begin
            d.stat.tx_buffer_empty = 1'b1;
         end
      end
      // Writes are dropped while tx_buffer_empty is clear; after an underrun a write can overwrite an unread received byte.
      if (sw.data_wr && tx_en && q.stat.tx_buffer_empty) begin
         d.dbuf = sw.wdata;
         d.stat.tx_buffer_empty = 1'b0;
      end

      case (q.st)
         bsp_pkg::BSP_IDLE: begin
            d.sck_lvl = 1'b0;
            d.bit_cnt = '0;
            d.first = 1'b1;
            d.pre_cnt = '0;
            if (enabled && master && (tx_en ? !q.stat.tx_buffer_empty : sw.data_wr)) begin
               d.shift = tx_en ? q.dbuf : bsp_pkg::BSP_FILL;
               if (tx_en) begin
                  d.stat.tx_buffer_empty = 1'b1;
               end
               d.ssv_lat = sw.select_value;
               d.st = framed ? bsp_pkg::BSP_PRE : bsp_pkg::BSP_SHIFT;
            end else if (enabled && !master && selected) begin
               d.shift = tx_ok && tx_en ? q.dbuf : bsp_pkg::BSP_FILL;
               if (tx_en && !q.stat.tx_buffer_empty) begin
                  d.stat.tx_buffer_empty = 1'b1;
               end
               d.st = bsp_pkg::BSP_SHIFT;
            end
         end

         bsp_pkg::BSP_PRE: begin
            if (baud_tick) begin
               d.sck_lvl = !q.sck_lvl;
               d.pre_cnt = 2'(q.pre_cnt + 2'h1);
               if (q.pre_cnt == 2'(bsp_pkg::BSP_PRE_HALVES - 2'h1)) begin
                  d.st = bsp_pkg::BSP_SHIFT;
               end
            end
         end

         bsp_pkg::BSP_SHIFT: begin
            if (master && baud_tick) begin
               d.sck_lvl = !q.sck_lvl;
            end
            if (sample_ev) begin
               d.inbit = rx_bit;
               d.bit_cnt = 4'(q.bit_cnt + 4'h1);
               if (cfg.sck_phase && q.bit_cnt == 4'(nbits - 4'h1)) begin
                  done_shift = {q.shift[6:0], rx_bit};
                  char_done = 1'b1;
               end
            end
            if (shift_ev) begin
               if (cfg.sck_phase && q.first) begin
                  d.first = 1'b0;
               end else begin
                  d.shift = {q.shift[6:0], q.inbit};
                  if (!cfg.sck_phase && q.bit_cnt == nbits) begin
                     done_shift = {q.shift[6:0], q.inbit};
                     char_done = 1'b1;
                  end
               end
            end
            if (char_done) begin
               d.bit_cnt = '0;
               d.first = 1'b1;
               if (tx_ok && rx_ok) begin
                  xfer = 1'b1;
               end else if (master && !framed) begin
                  d.shift = done_shift;
                  d.st = bsp_pkg::BSP_WAIT;
               end else begin
                  // Underrun or overrun: keep the received byte if there is room, send fill.
                  if (rx_en && !q.stat.rx_buffer_full) begin
                     d.dbuf = done_shift;
                     d.stat.rx_buffer_full = 1'b1;
                     d.stat.tx_buffer_empty = tx_en;
                  end
                  d.shift = bsp_pkg::BSP_FILL;
                  if (master) begin
                     d.st = bsp_pkg::BSP_IDLE;
                  end
               end
            end
            if (!master && !selected) begin
               d.st = bsp_pkg::BSP_IDLE;
            end
         end

         bsp_pkg::BSP_WAIT: begin
            if (tx_ok && rx_ok) begin
               xfer = 1'b1;
               d.st = bsp_pkg::BSP_SHIFT;
            end
         end

         default: begin
            d.st = bsp_pkg::BSP_IDLE;
         end
      endcase

      if (xfer) begin
         if (rx_en) begin
            d.dbuf = done_shift;
            d.stat.rx_buffer_full = 1'b1;
         end
         d.shift = tx_en ? q.dbuf : bsp_pkg::BSP_FILL;
         if (tx_en && !rx_en) begin
            d.stat.tx_buffer_empty = 1'b1;
         end
         d.ssv_lat = sw.select_value;
      end

      if (!enabled) begin
         d.st = bsp_pkg::BSP_IDLE;
         d.sck_lvl = 1'b0;
      end

      d.pin_out.sck = d.sck_lvl ^ cfg.sck_idle_level;
      d.pin_out.mosi = d.shift[7];
      d.pin_out.miso = d.shift[7];

      case (cfg.select_framing_mode)
         bsp_pkg::BSP_FRAME_PULSE: begin
            d.pin_out.ss_n = d.st != bsp_pkg::BSP_PRE;
         end
         bsp_pkg::BSP_FRAME_ALT: begin
            d.pin_out.ss_n = !(d.st != bsp_pkg::BSP_IDLE && d.ssv_lat);
         end
         default: begin
            d.pin_out.ss_n = !sw.select_value;
         end
      endcase

      d.pin_oe.sck = enabled && master;
      d.pin_oe.mosi = enabled && master;
      d.pin_oe.miso = enabled && !master && selected;
      d.pin_oe.ss_n = enabled && master && cfg.select_pin_direction;

      d.rdata = d.dbuf;
      d.stat.irq_tx = d.stat.tx_buffer_empty && tx_en;
      d.stat.irq_rx = d.stat.rx_buffer_full && rx_en;
      d.stat.busy = d.st != bsp_pkg::BSP_IDLE;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.first <= 1'b1;
         q.pin_out.ss_n <= 1'b1;
         q.stat.tx_buffer_empty <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign pins_out = q.pin_out;
   assign pins_oe = q.pin_oe;
   assign data_rdata = q.rdata;
   assign status = q.stat;

endmodule

// ---- verification/bsp_properties.sv ----
/* Checker for the serial port top: pin directions, clock rate and flags.
   Sees only the ports of bsp_top; attached by the bind at the foot. */
`timescale 1ns/1ps
module bsp_properties (
   input logic clk_sys,
   input logic rst_n,
   input bsp_pkg::bsp_cfg_t cfg,
   input bsp_pkg::bsp_sw_t sw,
   input bsp_pkg::bsp_pins_t pins_in,
   input bsp_pkg::bsp_pins_t pins_out,
   input bsp_pkg::bsp_pins_t pins_oe,
   input logic [7:0] data_rdata,
   input bsp_pkg::bsp_status_t status
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   bsp_pkg::bsp_cfg_t cfg_q;
   logic calm;
   logic on;
   logic mst;
   // Outputs are registered, so a relation to cfg holds only once cfg has settled.
   always_ff @(posedge clk_sys) cfg_q <= cfg;
   assign calm = (cfg == cfg_q);
   assign on = (cfg.direction_enable_pair != bsp_pkg::BSP_DIR_OFF);
   assign mst = cfg.master_mode_enable;
   chk_miso_master: assert property (calm && mst |-> !pins_oe.miso)
      else $error("master drives its receive line");
   chk_miso_slave: assert property ((!mst && on && !pins_in.ss_n)[*4] |-> pins_oe.miso)
      else $error("selected slave does not drive its output");
   chk_mosi_master: assert property (calm && mst && on |-> pins_oe.mosi)
      else $error("master leaves its transmit line undriven");
   chk_off_float: assert property (calm && !on |-> !pins_oe.mosi && !pins_oe.miso)
      else $error("disabled port drives a data line");
   chk_unsel_float: assert property ((!mst && pins_in.ss_n)[*4] |-> !pins_oe.miso)
      else $error("unselected slave drives its output");
   chk_sck_owner: assert property (calm && on |-> pins_oe.sck == mst)
      else $error("serial clock direction wrong");
   chk_sck_rate: assert property (calm && mst && cfg.baud_divisor > 16'h0001 && $changed(pins_out.sck) |=> $stable(pins_out.sck))
      else $error("serial clock faster than half the system clock");
   chk_sck_idle: assert property (calm && mst && on && !status.busy && $past(status.busy) == 1'b0
      |-> pins_out.sck == cfg.sck_idle_level)
      else $error("serial clock not at idle level");
   chk_write_start: assert property (mst && cfg.direction_enable_pair[1] && !status.busy
      && status.tx_buffer_empty && sw.data_wr |=> !status.tx_buffer_empty ##1 status.busy)
      else $error("buffer write did not start a transfer");
   chk_read_empty: assert property (sw.data_rd && status.rx_buffer_full &&
      cfg.direction_enable_pair == bsp_pkg::BSP_DIR_BOTH |=> status.tx_buffer_empty)
      else $error("read did not request next transmit byte");
   chk_irq_flags: assert property (calm |->
      status.irq_tx == (status.tx_buffer_empty && cfg.direction_enable_pair[1]) &&
      status.irq_rx == (status.rx_buffer_full && cfg.direction_enable_pair[0]))
      else $error("interrupt request does not follow its flag");
   cov_start: cover property (mst && sw.data_wr ##2 status.busy);
   cov_rx_full: cover property ($rose(status.rx_buffer_full));
   cov_slave_sel: cover property (!mst && pins_oe.miso);
endmodule

bind bsp_top bsp_properties chk_u (.clk_sys, .rst_n, .cfg, .sw, .pins_in, .pins_out,
   .pins_oe, .data_rdata, .status);

// ---- verification/bsp_ext_slave.sv ----
/* Behavioural external serial slave facing a master-mode port, mode 0 timing.
   Assumes an active-low select and eight-bit characters. */
`timescale 1ns/1ps
module bsp_ext_slave (
   input logic sck,
   input logic mosi,
   input logic ss_n,
   input logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic miso
);
   logic [7:0] tx_sh = 8'hFF;
   logic [7:0] rx_sh = 8'h00;
   int cnt = 0;
   initial rx_byte = 8'h00;
   always @(negedge ss_n) begin
      tx_sh = tx_byte;
      cnt = 0;
   end
   // Sample rising, count eight bits, MSB first.
   always @(posedge sck) begin
      if (!ss_n) begin
         rx_sh = {rx_sh[6:0], mosi};
         cnt = cnt + 1;
         if (cnt == 8) begin
            rx_byte = rx_sh;
            cnt = 0;
         end
      end
   end
   // Shift out on falling edge, reload at each character start.
   always @(negedge sck) begin
      if (!ss_n)
         tx_sh = (cnt == 0) ? tx_byte : {tx_sh[6:0], 1'b1};
   end
   // A released line shows the inverse so a stale bit never passes as a match.
   assign miso = ss_n ? ~tx_sh[7] : tx_sh[7];
endmodule

// ---- verification/tb_top.sv ----
/* Self-checking bench: master exchange with a slave model, slave exchange driven
   by the bench, pin directions and flags. Assumes package and design compiled first. */
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   bsp_pkg::bsp_cfg_t cfg;
   bsp_pkg::bsp_sw_t sw;
   bsp_pkg::bsp_pins_t pins_in;
   bsp_pkg::bsp_pins_t pins_out;
   bsp_pkg::bsp_pins_t pins_oe;
   bsp_pkg::bsp_status_t status;
   logic [7:0] data_rdata;
   logic l_sck = 1'b0;
   logic l_mosi = 1'b0;
   logic l_ss_n = 1'b1;
   logic m_miso;
   logic [7:0] m_rx;
   logic [7:0] m_tx = 8'h3C;
   logic [7:0] got;
   logic moved;
   int mismatches = 0;
   int tests_run = 0;
   // Each pin takes the design's level where it drives, else its far side.
   assign pins_in.sck = pins_oe.sck ? pins_out.sck : l_sck;
   assign pins_in.mosi = pins_oe.mosi ? pins_out.mosi : l_mosi;
   assign pins_in.miso = pins_oe.miso ? pins_out.miso : m_miso;
   assign pins_in.ss_n = pins_oe.ss_n ? pins_out.ss_n : l_ss_n;
   bsp_top dut_u (.clk_sys, .rst_n, .cfg, .sw, .pins_in, .pins_out, .pins_oe, .data_rdata,
      .status);
   bsp_ext_slave slv_u (.sck(pins_in.sck), .mosi(pins_in.mosi), .ss_n(pins_in.ss_n),
      .tx_byte(m_tx), .rx_byte(m_rx), .miso(m_miso));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp1(input string what, input logic exp, input logic seen);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return status.busy;
         1: return status.tx_buffer_empty;
         default: return status.rx_buffer_full;
      endcase
   endfunction
   task automatic wait_flag(input int sel, input logic val);
      int n;
      n = 0;
      while (pick(sel) !== val && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 3000) begin
         mismatches++;
         $display("wrong value flag %0d expected %b seen %b", sel, val, pick(sel));
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] val);
      sw.wdata = val;
      sw.data_wr = 1'b1;
      @(negedge clk_sys);
      sw.data_wr = 1'b0;
   endtask
   task automatic rd(output logic [7:0] val);
      val = data_rdata;
      sw.data_rd = 1'b1;
      @(negedge clk_sys);
      sw.data_rd = 1'b0;
   endtask
   // Bench as link master, mode 0, 80 ns period, well under an eighth of clk_sys.
   task automatic link_byte(input logic [7:0] mo, input logic sel_n, output logic [7:0] mi);
      l_ss_n = sel_n;
      repeat (10) @(negedge clk_sys);
      for (int i = 7; i >= 0; i--) begin
         l_mosi = mo[i];
         repeat (10) @(negedge clk_sys);
         l_sck = 1'b1;
         mi[i] = pins_in.miso;
         repeat (10) @(negedge clk_sys);
         l_sck = 1'b0;
      end
      repeat (10) @(negedge clk_sys);
      l_ss_n = 1'b1;
   endtask
   initial begin
      cfg = '0;
      sw = '0;
      repeat (19) @(negedge clk_sys);
      cmp1("reset tx empty", 1'b1, status.tx_buffer_empty);
      cmp8("reset enables", 8'h00, {4'h0, pins_oe});
      cmp1("reset select", 1'b1, pins_out.ss_n);
      @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      cfg.master_mode_enable = 1'b1;
      cfg.select_pin_direction = 1'b1;
      cfg.baud_divisor = 16'h0003;
      for (int d = 0; d < 4; d++) begin
         cfg.direction_enable_pair = 2'(d);
         repeat (3) @(negedge clk_sys);
         cmp1("irq tx", cfg.direction_enable_pair[1], status.irq_tx);
         cmp1("irq rx", 1'b0, status.irq_rx);
         cmp1("mosi enable", d != 0, pins_oe.mosi);
         cmp1("miso enable", 1'b0, pins_oe.miso);
      end
      for (int p = 1; p >= 0; p--) begin
         cfg.sck_idle_level = 1'(p);
         repeat (3) @(negedge clk_sys);
         cmp1("sck idle", cfg.sck_idle_level, pins_out.sck);
         cmp1("sck enable", 1'b1, pins_oe.sck);
      end
      sw.select_value = 1'b1;
      repeat (3) @(negedge clk_sys);
      wr(8'hA5);
      wait_flag(0, 1'b1);
      wait_flag(1, 1'b1);
      wr(8'h5A);
      wait_flag(2, 1'b1);
      cmp8("first rx", m_tx, data_rdata);
      cmp8("slave got", 8'hA5, m_rx);
      repeat (80) @(negedge clk_sys);
      moved = 1'b0;
      repeat (40) begin
         @(negedge clk_sys);
         if (pins_out.sck !== 1'b0)
            moved = 1'b1;
      end
      cmp1("sck halted", 1'b0, moved);
      cmp8("second char", 8'h5A, m_rx);
      rd(got);
      cmp8("read rx", m_tx, got);
      @(negedge clk_sys);
      cmp1("tx empty after read", 1'b1, status.tx_buffer_empty);
      wr(8'h0F);
      wait_flag(2, 1'b1);
      cmp8("second rx", m_tx, data_rdata);
      repeat (80) @(negedge clk_sys);
      cmp8("third char", 8'h0F, m_rx);
      cmp1("irq rx set", 1'b1, status.irq_rx);
      rd(got);
      cmp8("third rx", m_tx, got);
      cfg.direction_enable_pair = bsp_pkg::BSP_DIR_OFF;
      repeat (3) @(negedge clk_sys);
      cmp1("off mosi", 1'b0, pins_oe.mosi);
      cmp1("off miso", 1'b0, pins_oe.miso);
      // A pulse-framed one-way run must frame itself and stop once data runs out.
      cfg.direction_enable_pair = bsp_pkg::BSP_DIR_TX_ONLY;
      cfg.select_framing_mode = bsp_pkg::BSP_FRAME_PULSE;
      repeat (3) @(negedge clk_sys);
      cmp1("pulse idle select", 1'b1, pins_out.ss_n);
      wr(8'hC3);
      moved = 1'b0;
      repeat (200) begin
         @(negedge clk_sys);
         if (pins_out.ss_n === 1'b0)
            moved = 1'b1;
      end
      cmp1("pulse seen", 1'b1, moved);
      cmp1("pulse run ended", 1'b0, status.busy);
      rst_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      cfg.master_mode_enable = 1'b0;
      cfg.select_pin_direction = 1'b0;
      cfg.direction_enable_pair = bsp_pkg::BSP_DIR_BOTH;
      repeat (3) @(negedge clk_sys);
      cmp1("slave sck enable", 1'b0, pins_oe.sck);
      wr(8'h96);
      link_byte(8'hF0, 1'b1, got);
      cmp1("ignored edges", 1'b0, status.rx_buffer_full);
      cmp1("unselected miso", 1'b0, pins_oe.miso);
      link_byte(8'h69, 1'b0, got);
      cmp8("slave tx", 8'h96, got);
      wait_flag(2, 1'b1);
      cmp8("slave rx", 8'h69, data_rdata);
      final_report();
   end
endmodule
